/* File: rtl/gmc_dev_end.sv */
// gmc_dev_end: instrument end, decodes multiline commands and passes data.
// assumes the controller end drives the bus; address switches are static.
module gmc_dev_end
    import gmc_pkg::*;
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic              ce,
    // address switches
    input  wire logic [ADDR_W-1:0] addr_sw,
    // bus
    gmc_bus_if.dev                 bus,
    // addressed state
    output logic                   listener,
    output logic                   talker,
    output logic                   remote,
    output logic                   panel_locked,
    output logic                   poll_mode,
    output logic [ADDR_W-1:0]      own_addr,
    // event pulses
    output logic                   clear_pulse,
    output logic                   trigger_pulse,
    output logic                   standby_select_command,
    // device-dependent data
    output logic                   dd_valid,
    output logic [BYTE_W-1:0]      dd_data,
    input  wire logic              dd_ready
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic gmc_cmd_t classify(input logic [BYTE_W-1:0] b);
        logic [6:0] c;
        c = b[6:0];
        case (c)
            CODE_GO_LOCAL:   classify = GMC_GO_LOCAL;
            CODE_SEL_CLEAR:  classify = GMC_SEL_CLEAR;
            CODE_GROUP_TRIG: classify = GMC_GROUP_TRIG;
            CODE_LOCKOUT:    classify = GMC_LOCKOUT;
            CODE_DEV_CLEAR:  classify = GMC_DEV_CLEAR;
            CODE_POLL_ON:    classify = GMC_POLL_ON;
            CODE_POLL_OFF:   classify = GMC_POLL_OFF;
            CODE_UNLISTEN:   classify = GMC_UNLISTEN;
            CODE_UNTALK:     classify = GMC_UNTALK;
            default: begin
                case (c[GRP_HI:GRP_LO])
                    GRP_LISTEN:    classify = GMC_LISTEN;
                    GRP_TALK:      classify = GMC_TALK;
                    GRP_SECONDARY: classify = GMC_SECONDARY;
                    default:       classify = GMC_NONE;
                endcase
            end
        endcase
    endfunction : classify

    logic [BYTE_W-1:0] bus_byte;
    logic              bus_ready;
    logic              taken;
    logic              cmd_take;
    logic              data_take;
    gmc_cmd_t          cmd;
    logic              addr_hit;
    logic              do_clear;

    logic              addr_loaded_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic              listen_reg;
    logic              talk_reg;
    logic              remote_reg;
    logic              lock_reg;
    logic              poll_reg;
    logic              clear_reg;
    logic              trig_reg;
    logic              stby_reg;
    logic [1:0]        stby_step_reg;
    logic              push;

    assign bus_byte  = ~bus.dio_n;
    assign taken     = ce && bus.byte_valid && bus_ready;
    assign cmd_take  = taken && !bus.atn_n;
    assign data_take = taken && bus.atn_n && listen_reg;
    assign cmd       = classify(bus_byte);
    // own address sits in the low five bits of either address group
    assign addr_hit  = (bus_byte[ADDR_W-1:0] == addr_reg) && addr_loaded_reg;
    assign do_clear  = cmd_take && ((cmd == GMC_DEV_CLEAR) ||
                                    (cmd == GMC_SEL_CLEAR && listen_reg));
    assign push      = data_take;

    assign bus.byte_ready = bus_ready;

    // ------------------------------------------------------------
    // primary address, caught once after reset release
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            addr_loaded_reg <= 1'b0;
            addr_reg        <= ADDR_RESET;
        end else if (ce && !addr_loaded_reg) begin
            addr_loaded_reg <= 1'b1;
            // address 31 would alias the unaddress codes, so it is clamped
            addr_reg        <= (addr_sw > ADDR_MAX) ? ADDR_MAX : addr_sw;
        end
    end

    // ------------------------------------------------------------
    // listener and talker
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            listen_reg <= 1'b0;
            talk_reg   <= 1'b0;
        end else if (ce) begin
            if (!bus.ifc_n) begin
                listen_reg <= 1'b0;
                talk_reg   <= 1'b0;
            end else if (cmd_take) begin
                case (cmd)
                    GMC_UNLISTEN: listen_reg <= 1'b0;
                    GMC_UNTALK:   talk_reg   <= 1'b0;
                    GMC_LISTEN: begin
                        if (addr_hit) begin
                            listen_reg <= 1'b1;
                        end
                    end
                    GMC_TALK: begin
                        talk_reg <= addr_hit;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // remote, lockout and serial poll
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            remote_reg <= 1'b0;
            lock_reg   <= 1'b0;
            poll_reg   <= 1'b0;
        end else if (ce) begin
            if (bus.ren_n) begin
                // remote enable released hands the panel back
                remote_reg <= 1'b0;
                lock_reg   <= 1'b0;
            end else if (cmd_take) begin
                case (cmd)
                    GMC_LISTEN: begin
                        if (addr_hit) begin
                            remote_reg <= 1'b1;
                        end
                    end
                    GMC_LOCKOUT:  lock_reg <= 1'b1;
                    GMC_GO_LOCAL: begin
                        if (listen_reg) begin
                            remote_reg <= 1'b0;
                            lock_reg   <= 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (cmd_take && cmd == GMC_POLL_ON) begin
                poll_reg <= 1'b1;
            end else if (cmd_take && cmd == GMC_POLL_OFF) begin
                poll_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // clear and trigger pulses
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            clear_reg <= 1'b0;
            trig_reg  <= 1'b0;
        end else if (ce) begin
            clear_reg <= do_clear;
            trig_reg  <= cmd_take && (cmd == GMC_GROUP_TRIG) && listen_reg;
        end
    end

    // ------------------------------------------------------------
    // standby string detection on accepted data
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stby_step_reg <= 2'd0;
            stby_reg      <= 1'b0;
        end else if (ce) begin
            stby_reg <= 1'b0;
            if (do_clear) begin
                stby_step_reg <= 2'd0;
            end else if (data_take) begin
                case (stby_step_reg)
                    2'd0: stby_step_reg <= (bus_byte == STBY_CHAR0) ? 2'd1 : 2'd0;
                    2'd1: stby_step_reg <= (bus_byte == STBY_CHAR1) ? 2'd2 :
                                           (bus_byte == STBY_CHAR0) ? 2'd1 : 2'd0;
                    default: begin
                        stby_step_reg <= (bus_byte == STBY_CHAR0) ? 2'd1 : 2'd0;
                        stby_reg      <= (bus_byte == STBY_CHAR2);
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // data path: a stalled reader backs up the bus, no byte lost
    // ------------------------------------------------------------
    gmc_buf2 u_buf (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .ce        (ce),
        .in_valid  (push),
        .in_data   (bus_byte),
        .in_ready  (bus_ready),
        .out_valid (dd_valid),
        .out_data  (dd_data),
        .out_ready (dd_ready)
    );

    assign listener               = listen_reg;
    assign talker                 = talk_reg;
    assign remote                 = remote_reg;
    assign panel_locked           = lock_reg;
    assign poll_mode              = poll_reg;
    assign own_addr               = addr_reg;
    assign clear_pulse            = clear_reg;
    assign trigger_pulse          = trig_reg;
    assign standby_select_command = stby_reg;
endmodule : gmc_dev_end

/* File: common/gmc_pkg.sv */
// gmc_pkg: constants shared by both bus ends and the skid buffer.
// assumes bus levels are low-true on the wire and byte codes are 7-bit.
package gmc_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int           BYTE_W    = 8;
    localparam int           ADDR_W    = 5;
    localparam int           BUF_DEPTH = 2;
    // ------------------------------------------------------------
    // command codes, bit 7 taken as zero
    // ------------------------------------------------------------
    localparam logic [6:0]   CODE_GO_LOCAL     = 7'h01;
    localparam logic [6:0]   CODE_SEL_CLEAR    = 7'h04;
    localparam logic [6:0]   CODE_GROUP_TRIG   = 7'h08;
    localparam logic [6:0]   CODE_LOCKOUT      = 7'h11;
    localparam logic [6:0]   CODE_DEV_CLEAR    = 7'h14;
    localparam logic [6:0]   CODE_POLL_ON      = 7'h18;
    localparam logic [6:0]   CODE_POLL_OFF     = 7'h19;
    localparam logic [6:0]   CODE_UNLISTEN     = 7'h3F;
    localparam logic [6:0]   CODE_UNTALK       = 7'h5F;
    // group field: bits 6:5 of the code
    localparam logic [1:0]   GRP_CTRL          = 2'h0;
    localparam logic [1:0]   GRP_LISTEN        = 2'h1;
    localparam logic [1:0]   GRP_TALK          = 2'h2;
    localparam logic [1:0]   GRP_SECONDARY     = 2'h3;
    localparam int           GRP_HI            = 6;
    localparam int           GRP_LO            = 5;
    // ------------------------------------------------------------
    // primary address and standby string
    // ------------------------------------------------------------
    localparam logic [4:0]   ADDR_MAX          = 5'h1E;
    localparam logic [4:0]   ADDR_RESET        = 5'h00;
    localparam logic [7:0]   STBY_CHAR0        = 8'h46;
    localparam logic [7:0]   STBY_CHAR1        = 8'h30;
    localparam logic [7:0]   STBY_CHAR2        = 8'h58;
    localparam logic [7:0]   BYTE_ZERO         = 8'h00;
    localparam logic [7:0]   BYTE_IDLE_N       = 8'hFF;

    typedef enum logic [3:0] {
        GMC_NONE, GMC_GO_LOCAL, GMC_SEL_CLEAR, GMC_GROUP_TRIG, GMC_LOCKOUT,
        GMC_DEV_CLEAR, GMC_POLL_ON, GMC_POLL_OFF, GMC_LISTEN, GMC_TALK,
        GMC_UNLISTEN, GMC_UNTALK, GMC_SECONDARY
    } gmc_cmd_t;
endpackage : gmc_pkg

/* File: common/gmc_bus_if.sv */
// gmc_bus_if: multiline command bus between controller end and device end.
// assumes one controller; byte transfer is valid/ready in place of the handshake.
interface gmc_bus_if;
    logic       atn_n;
    logic       ifc_n;
    logic       ren_n;
    logic [7:0] dio_n;
    logic       byte_valid;
    logic       byte_ready;

    modport ctrl (
        output atn_n,
        output ifc_n,
        output ren_n,
        output dio_n,
        output byte_valid,
        input  byte_ready
    );
    modport dev (
        input  atn_n,
        input  ifc_n,
        input  ren_n,
        input  dio_n,
        input  byte_valid,
        output byte_ready
    );
endinterface : gmc_bus_if

/* File: rtl/gmc_buf2.sv */
// gmc_buf2: two-entry buffer with valid/ready on both sides.
// assumes one clock; in_ready comes from a flop of the fill count.
module gmc_buf2
    import gmc_pkg::*;
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic              ce,
    // fill side
    input  wire logic              in_valid,
    input  wire logic [BYTE_W-1:0] in_data,
    output logic                   in_ready,
    // drain side
    output logic                   out_valid,
    output logic [BYTE_W-1:0]      out_data,
    input  wire logic              out_ready
);
    logic [BYTE_W-1:0] mem [BUF_DEPTH];
    logic              wr_ptr_reg;
    logic              rd_ptr_reg;
    logic [1:0]        count_reg;
    logic              push;
    logic              pop;

    assign push      = ce && in_valid && in_ready;
    assign pop       = ce && out_valid && out_ready;
    assign in_ready  = (count_reg != 2'(BUF_DEPTH));
    assign out_valid = (count_reg != 2'd0);
    assign out_data  = mem[rd_ptr_reg];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            // simultaneous push and pop leaves the count alone
            if (push && !pop) begin
                count_reg <= count_reg + 2'd1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 2'd1;
            end
        end
    end
endmodule : gmc_buf2

/* File: rtl/gmc_ctrl_end.sv */
// gmc_ctrl_end: system controller end, drives attention, clear and bytes.
// assumes the user holds cmd_* until cmd_ready is seen with cmd_valid.
module gmc_ctrl_end
    import gmc_pkg::*;
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic              ce,
    // user request
    input  wire logic              cmd_valid,
    input  wire logic              cmd_atn,
    input  wire logic [BYTE_W-1:0] cmd_data,
    output logic                   cmd_ready,
    input  wire logic              ifc_req,
    input  wire logic              ren_req,
    // bus
    gmc_bus_if.ctrl                bus
);
    logic busy_reg;

    // ------------------------------------------------------------
    // byte launch: atn and data stand together until taken
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            busy_reg       <= 1'b0;
            cmd_ready      <= 1'b1;
            bus.byte_valid <= 1'b0;
            bus.atn_n      <= 1'b1;
            bus.dio_n      <= BYTE_IDLE_N;
        end else if (ce) begin
            if (!busy_reg && cmd_valid) begin
                busy_reg       <= 1'b1;
                cmd_ready      <= 1'b0;
                bus.byte_valid <= 1'b1;
                bus.atn_n      <= ~cmd_atn;
                bus.dio_n      <= ~cmd_data;
            end else if (busy_reg && bus.byte_ready) begin
                busy_reg       <= 1'b0;
                cmd_ready      <= 1'b1;
                bus.byte_valid <= 1'b0;
                // atn stays where it was so a sequence keeps it low
            end
        end
    end

    // ------------------------------------------------------------
    // uniline levels
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bus.ifc_n <= 1'b1;
            bus.ren_n <= 1'b1;
        end else if (ce) begin
            bus.ifc_n <= ~ifc_req;
            bus.ren_n <= ~ren_req;
        end
    end
endmodule : gmc_ctrl_end

/* File: dv/gmc_bus_assertions.sv */
// gmc_bus_assertions: wire and decode checks on the joined bus.
// assumes ce held high by the bench; instantiated beside the interface.
module gmc_bus_assertions
    import gmc_pkg::*;
(
    // clock and reset
    input wire logic              sys_clk,
    input wire logic              reset,
    input wire logic              ce,
    // bus
    input wire logic              atn_n,
    input wire logic              ifc_n,
    input wire logic [7:0]        dio_n,
    input wire logic              byte_valid,
    input wire logic              byte_ready,
    // device state
    input wire logic              listener,
    input wire logic              talker,
    input wire logic [ADDR_W-1:0] own_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       tk;
    logic       cmd;
    logic [6:0] code;
    // bit 7 dropped: commands are matched on seven bits
    assign tk   = byte_valid && byte_ready && ce;
    assign cmd  = tk && !atn_n;
    assign code = ~dio_n[6:0];
    default clocking cb @(posedge sys_clk); endclocking

    AST_RESET_IDLE: assert property (reset |=> atn_n && ifc_n && !byte_valid && dio_n == 8'hFF && !listener && !talker)
        else $error("bus or addressed state not idle after reset");
    AST_HOLD_BYTE: assert property (disable iff (reset) byte_valid && !(byte_ready && ce) |=> byte_valid && $stable(dio_n) && $stable(atn_n))
        else $error("offered byte changed before it was taken");
    AST_DROP_TAKEN: assert property (disable iff (reset) tk |=> !byte_valid)
        else $error("byte still offered after it was taken");
    AST_UNLISTEN: assert property (disable iff (reset) cmd && code == 7'h3F |-> ##[1:2] !listener)
        else $error("listener kept after unlisten");
    AST_UNTALK: assert property (disable iff (reset) cmd && code == 7'h5F |-> ##[1:2] !talker)
        else $error("talker kept after untalk");
    AST_OWN_LISTEN: assert property (disable iff (reset) cmd && code[6:5] == GRP_LISTEN && code[4:0] == own_addr |-> ##[1:2] listener)
        else $error("own listen address not taken");
    AST_FOREIGN_TALK: assert property (disable iff (reset) cmd && code[6:5] == GRP_TALK && code[4:0] != own_addr |-> ##[1:2] !talker)
        else $error("talker kept after foreign talk address");
    AST_IFC_DROP: assert property (disable iff (reset) !ifc_n |-> ##[1:2] !listener && !talker)
        else $error("addressed state kept during interface clear");
endmodule : gmc_bus_assertions

/* File: dv/tb_top.sv */
// tb_top: both bus ends joined, bench model of the decoder state.
// assumes gmc_pkg, gmc_bus_if and the rtl ends compiled before.
module tb_top
    import gmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------
    // signals
    // ----------------
    logic              sys_clk, reset, ce, cmd_valid, cmd_atn, cmd_ready, ifc_req, ren_req;
    logic              listener, talker, remote, panel_locked, poll_mode, dd_valid, dd_ready, hold;
    logic              clear_pulse, trigger_pulse, standby_select_command;
    logic [7:0]        cmd_data, dd_data, q[$];
    logic [ADDR_W-1:0] addr_sw, own_addr;
    logic [31:0]       seed = 32'h541b_52c3;
    int                n_mismatch, n_tests, n_clr, n_trg, n_sby, m_clr, m_trg, m_sby, m_st;
    logic [4:0]        m_addr;
    // universal then addressed-without-listener, addressed sequence, talk and secondary bytes
    localparam logic [7:0] SEQ_UNIV [7] = '{8'h18, 8'h19, 8'h14, 8'h01, 8'h04, 8'h08, 8'h41};
    localparam logic [7:0] SEQ_ADDR [8] = '{8'hBF, 8'hAC, 8'h04, 8'h08, 8'h01, 8'h46, 8'h30, 8'h58};
    localparam logic [7:0] SEQ_TALK [7] = '{8'h4C, 8'h45, 8'h4C, 8'h5F, 8'h4C, 8'h6C, 8'h7F};
    bit                m_lis, m_tlk, m_rem, m_poll;

    gmc_bus_if gmc_bus_if_i ();
    gmc_ctrl_end gmc_ctrl_end_i (.sys_clk(sys_clk), .reset(reset), .ce(ce), .cmd_valid(cmd_valid),
        .cmd_atn(cmd_atn), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .ifc_req(ifc_req),
        .ren_req(ren_req), .bus(gmc_bus_if_i));
    gmc_dev_end gmc_dev_end_i (.sys_clk(sys_clk), .reset(reset), .ce(ce), .addr_sw(addr_sw),
        .bus(gmc_bus_if_i), .listener(listener), .talker(talker), .remote(remote),
        .panel_locked(panel_locked), .poll_mode(poll_mode), .own_addr(own_addr),
        .clear_pulse(clear_pulse), .trigger_pulse(trigger_pulse),
        .standby_select_command(standby_select_command), .dd_valid(dd_valid), .dd_data(dd_data),
        .dd_ready(dd_ready));
    gmc_bus_assertions gmc_bus_assertions_i (.sys_clk(sys_clk), .reset(reset), .ce(ce),
        .atn_n(gmc_bus_if_i.atn_n), .ifc_n(gmc_bus_if_i.ifc_n), .dio_n(gmc_bus_if_i.dio_n),
        .byte_valid(gmc_bus_if_i.byte_valid), .byte_ready(gmc_bus_if_i.byte_ready),
        .listener(listener), .talker(talker), .own_addr(own_addr));

    always #5 sys_clk = ~sys_clk;
    // ----------------
    // helpers
    // ----------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // receiver stalls at random so the two-entry buffer gets exercised
    always @(negedge sys_clk) dd_ready <= !hold && (rnd() % 3 != 0);
    always @(posedge sys_clk) begin
        n_clr += int'(clear_pulse === 1'b1);
        n_trg += int'(trigger_pulse === 1'b1);
        n_sby += int'(standby_select_command === 1'b1);
        if (!reset && dd_valid === 1'b1 && dd_ready === 1'b1) begin
            if (q.size() == 0)
                check(1, 0);
            else
                check(dd_data, q.pop_front());
        end
    end

    task automatic model(input bit atn, input logic [7:0] b);
        if (atn && b[6:5] == GRP_LISTEN) begin
            if (b[6:0] == 7'h3F)
                m_lis = 0;
            else if (b[4:0] == m_addr) begin
                m_lis = 1;
                m_rem = ren_req;
            end
        end else if (atn && b[6:5] == GRP_TALK)
            m_tlk = (b[6:0] != 7'h5F && b[4:0] == m_addr);
        else if (atn && b[6:5] == GRP_CTRL) begin
            case (b[6:0])
                7'h01: if (m_lis) m_rem = 0;
                7'h04: if (m_lis) begin m_clr++; m_st = 0; end
                7'h08: if (m_lis) m_trg++;
                7'h14: begin m_clr++; m_st = 0; end
                7'h18: m_poll = 1;
                7'h19: m_poll = 0;
                default: ;
            endcase
        end else if (!atn && m_lis) begin
            q.push_back(b);
            if (b == 8'h46) m_st = 1;
            else if (m_st == 1 && b == 8'h30) m_st = 2;
            else if (m_st == 2 && b == 8'h58) begin m_st = 0; m_sby++; end
            else m_st = 0;
        end
    endtask : model

    task automatic put(input bit atn, input logic [7:0] b);
        @(negedge sys_clk);
        cmd_valid = 1;
        cmd_atn = atn;
        cmd_data = b;
        @(negedge sys_clk);
        cmd_valid = 0;
    endtask : put

    task automatic fin();
        int k;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 100) begin
            @(negedge sys_clk);
            k++;
        end
        if (k == 100) check(0, 1);
    endtask : fin

    task automatic send(input bit atn, input logic [7:0] b);
        put(atn, b);
        fin();
        model(atn, b);
        repeat (3) @(negedge sys_clk);
        check(listener, m_lis);
        check(talker, m_tlk);
        check(remote, m_rem);
        check(poll_mode, m_poll);
        check(n_clr, m_clr);
        check(n_trg, m_trg);
        check(n_sby, m_sby);
    endtask : send

    task automatic do_reset(input logic [4:0] a);
        reset = 1;
        addr_sw = a;
        repeat (20) @(negedge sys_clk);
        reset = 0;
        // switches above thirty are taken as thirty
        m_addr = (a == 5'h1F) ? 5'h1E : a;
        {m_lis, m_tlk, m_rem, m_poll} = 4'h0;
        m_st = 0;
        repeat (3) @(negedge sys_clk);
    endtask : do_reset

    initial begin
        #200_000;
        n_mismatch++;
        print_verdict();
    end
    // ----------------
    // scenarios
    // ----------------
    initial begin
        logic [31:0] r;
        {sys_clk, ce, cmd_valid, cmd_atn, cmd_data, ifc_req, ren_req, hold} = 15'h2000;
        do_reset(5'h1F);
        check(own_addr, 5'h1E);
        do_reset(5'h0C);
        addr_sw = 5'h03;
        ren_req = 1;
        repeat (3) @(negedge sys_clk);
        check(own_addr, 5'h0C);
        send(1, 8'h11);
        check(panel_locked, 1);
        for (int i = 0; i < 7; i++) send(i < 6, SEQ_UNIV[i]);
        // bit 7 set on unlisten and listen bytes
        for (int i = 0; i < 8; i++) send(i < 5, SEQ_ADDR[i]);
        repeat (30) @(negedge sys_clk);
        hold = 1;
        send(0, 8'h11);
        send(0, 8'h22);
        check(gmc_bus_if_i.byte_ready, 0);
        put(0, 8'h33);
        repeat (6) @(negedge sys_clk);
        check(cmd_ready, 0);
        hold = 0;
        fin();
        model(0, 8'h33);
        for (int i = 0; i < 7; i++) send(1, SEQ_TALK[i]);
        ifc_req = 1;
        repeat (3) @(negedge sys_clk);
        ifc_req = 0;
        repeat (3) @(negedge sys_clk);
        check(listener, 0);
        check(talker, 0);
        m_lis = 0;
        m_tlk = 0;
        send(1, 8'h2C);
        repeat (150) begin
            r = rnd();
            send(r[9:8] == 2'h0, (r[7:0] == 8'h46) ? 8'h47 : r[7:0]);
        end
        ren_req = 0;
        repeat (30) @(negedge sys_clk);
        check(remote, 0);
        check(panel_locked, 0);
        check(q.size(), 0);
        print_verdict();
    end
endmodule : tb_top
